// ==== core/krgc_regs.vh ====
// register map, field positions, reset values and timing for the keyboard reset/gate config
`ifndef KRGC_REGS_VH
`define KRGC_REGS_VH

// register indices; byte address is four times the index
`define KRGC_IDX_SELECT 8'hF0
`define KRGC_IDX_RSVD_LO 8'hF1
`define KRGC_IDX_RSVD_HI 8'hFF
`define KRGC_IDX_PORT92 8'h92
`define KRGC_IDX_STATUS 8'hE0

// select register fields
`define KRGC_SEL_POL_BIT 7
`define KRGC_SEL_P92_BIT 2
`define KRGC_SEL_GATE_BIT 1
`define KRGC_SEL_RST_BIT 0
`define KRGC_SEL_WMASK 8'h87
`define KRGC_SEL_RESET 8'h00

// fast port-92 register fields
`define KRGC_P92_GATE_BIT 1
`define KRGC_P92_RST_BIT 0
`define KRGC_P92_WMASK 8'h03
`define KRGC_P92_RESET 8'h00

// status register fields
`define KRGC_STA_GATE_BIT 0
`define KRGC_STA_RST_BIT 1
`define KRGC_STA_PORT_BIT 2

// reset pulse timing
`define KRGC_CLK_MHZ 200
`define KRGC_RST_PULSE_NS 500
`define KRGC_RST_PULSE_CYC ((`KRGC_RST_PULSE_NS * `KRGC_CLK_MHZ + 999) / 1000)
`define KRGC_CNT_W 8

`endif

// ==== core/krgc_sync2.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module krgc_sync2 #(
	parameter W = 1
) (
	// clock and reset
	input wire mclk_in,
	input wire rst_in,
	// raw and synchronised levels
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_r;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // krgc_sync2

// ==== core/krgc_top.v ====
// keyboard reset and address-line-20 gate configuration block with apb access
//
// Behaviour
// R01 - select bit 7 sets keyboard port output polarity: 0 active low, 1 active high
// R02 - select bit 2 set enables fast port-92 function, cleared disables it
// R03 - bit 1 picks gate control, bit 0 reset control: 0 software, 1 hardware
// R04 - indices 0xF1 to 0xFF are reserved and read as zero
// R05 - select register clears on reset; bits 6 to 3 always read zero
`timescale 1ns/1ps
`include "krgc_regs.vh"
module krgc_top (
	// clock and reset
	input wire mclk_in,
	input wire rst_in,
	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	// keyboard controller port levels (asynchronous pins)
	input wire kbd_port_output_bit_in,
	input wire ctl_address_line20_gate_in,
	input wire ctl_keyboard_system_reset_in,
	// hardware speed-up requests from host decode (same clock, one-cycle pulses)
	input wire hw_gate_set_in,
	input wire hw_gate_clr_in,
	input wire hw_reset_req_in,
	// outputs to the system
	output reg kbd_port_output_bit_out,
	output reg address_line20_gate_out,
	output reg keyboard_system_reset_out
);
	// pulse length in cycles, cut to the counter width on purpose
	localparam integer RST_CYC_FULL = `KRGC_RST_PULSE_CYC;
	localparam [`KRGC_CNT_W-1:0] RST_CYC = RST_CYC_FULL[`KRGC_CNT_W-1:0];

	reg [7:0] kbd_reset_gate_select_reg_r;
	reg [7:0] port92_r;
	reg hw_gate_r;
	reg [`KRGC_CNT_W-1:0] rst_cnt_r;
	reg [`KRGC_CNT_W-1:0] rst_cnt_nxt;
	reg [31:0] rdata_nxt;
	reg err_nxt;
	wire [2:0] pin_sync;
	wire port_bit_s;
	wire ctl_gate_s;
	wire ctl_rst_s;
	wire [9:0] idx;
	wire addr_ok;
	wire setup;
	wire wr_en;
	wire sel_pol;
	wire sel_p92;
	wire sel_gate;
	wire sel_rst;
	wire p92_rst_rise;
	wire gate_nxt;
	wire rst_nxt;
	wire port_nxt;
	wire sel_hit;
	wire rsvd_hit;
	wire p92_hit;
	wire sta_hit;
	wire sel_wr;
	wire p92_wr;
	wire pulse_req;
	wire [2:0] status_word;

	// pins are asynchronous: two flops before any logic reads them
	krgc_sync2 #(
		.W(3)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in({kbd_port_output_bit_in, ctl_address_line20_gate_in,
			ctl_keyboard_system_reset_in}),
		.sync_out(pin_sync)
	);

	assign port_bit_s = pin_sync[2];
	assign ctl_gate_s = pin_sync[1];
	assign ctl_rst_s = pin_sync[0];

	// bus decode: word index from byte address
	assign idx = paddr_in[11:2];
	assign addr_ok = (paddr_in[1:0] == 2'h0);
	assign setup = psel_in && !penable_in;
	assign wr_en = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];

	// register decode; a misaligned byte address hits nothing
	assign sel_hit = addr_ok && (idx == {2'h0, `KRGC_IDX_SELECT});
	assign rsvd_hit = addr_ok && (idx >= {2'h0, `KRGC_IDX_RSVD_LO})
		&& (idx <= {2'h0, `KRGC_IDX_RSVD_HI});
	assign p92_hit = addr_ok && (idx == {2'h0, `KRGC_IDX_PORT92});
	assign sta_hit = addr_ok && (idx == {2'h0, `KRGC_IDX_STATUS});
	assign sel_wr = wr_en && sel_hit;
	assign p92_wr = wr_en && p92_hit;

	assign sel_pol = kbd_reset_gate_select_reg_r[`KRGC_SEL_POL_BIT];
	assign sel_p92 = kbd_reset_gate_select_reg_r[`KRGC_SEL_P92_BIT];
	assign sel_gate = kbd_reset_gate_select_reg_r[`KRGC_SEL_GATE_BIT];
	assign sel_rst = kbd_reset_gate_select_reg_r[`KRGC_SEL_RST_BIT];

	// status shows the registered outputs as the system sees them
	assign status_word = {kbd_port_output_bit_out, keyboard_system_reset_out,
		address_line20_gate_out};

	// read data and error, captured at the setup edge
	always @* begin
		rdata_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		if (!addr_ok) begin
			err_nxt = 1'b1;
		end else if (sel_hit) begin
			rdata_nxt = {24'h00_0000, kbd_reset_gate_select_reg_r}; // R05
		end else if (rsvd_hit) begin
			rdata_nxt = 32'h0000_0000; // R04
		end else if (p92_hit) begin
			// port-92 reads back zero while the function is off
			rdata_nxt = {24'h00_0000, sel_p92 ? port92_r : 8'h00}; // R02
		end else if (sta_hit) begin
			rdata_nxt = {29'h0000_0000, status_word};
		end else begin
			err_nxt = 1'b1;
		end
	end

	// zero-wait apb answer: pready in the first access cycle
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= setup;
			if (setup) begin
				prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
				pslverr_out <= err_nxt;
			end else if (pready_out) begin
				prdata_out <= 32'h0000_0000;
				pslverr_out <= 1'b0;
			end
		end
	end

	// select register; reserved bits never stored
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			kbd_reset_gate_select_reg_r <= `KRGC_SEL_RESET; // R05
		end else if (sel_wr) begin
			kbd_reset_gate_select_reg_r <= pwdata_in[7:0] & `KRGC_SEL_WMASK; // R05
		end
	end

	// fast port-92 register, writable only while enabled
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			port92_r <= `KRGC_P92_RESET;
		end else if (!sel_p92) begin
			port92_r <= `KRGC_P92_RESET; // R02
		end else if (p92_wr) begin
			port92_r <= pwdata_in[7:0] & `KRGC_P92_WMASK; // R02
		end
	end

	// a 0 to 1 write of the port-92 reset bit fires one reset pulse
	assign p92_rst_rise = sel_p92 && p92_wr
		&& pwdata_in[`KRGC_P92_RST_BIT] && !port92_r[`KRGC_P92_RST_BIT]; // R02
	assign pulse_req = (sel_rst && hw_reset_req_in) || p92_rst_rise; // R03

	// hardware speed-up gate latch, set wins over clear
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			hw_gate_r <= 1'b0;
		end else if (hw_gate_set_in) begin
			hw_gate_r <= 1'b1;
		end else if (hw_gate_clr_in) begin
			hw_gate_r <= 1'b0;
		end
	end

	// reset pulse stretcher for hardware and port-92 requests
	always @* begin
		rst_cnt_nxt = rst_cnt_r;
		// a new request restarts the count rather than extending it
		if (pulse_req) begin // R03
			rst_cnt_nxt = RST_CYC;
		end else if (rst_cnt_r != {`KRGC_CNT_W{1'b0}}) begin
			rst_cnt_nxt = rst_cnt_r - {{(`KRGC_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_cnt_r <= {`KRGC_CNT_W{1'b0}};
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
		end
	end

	// output steering
	// port-92 gate bit forces the gate open whichever source is selected
	assign gate_nxt = (sel_gate ? hw_gate_r : ctl_gate_s) // R03
		| (sel_p92 & port92_r[`KRGC_P92_GATE_BIT]); // R02
	assign rst_nxt = (rst_cnt_nxt != {`KRGC_CNT_W{1'b0}})
		| (!sel_rst & ctl_rst_s); // R03
	assign port_nxt = sel_pol ? port_bit_s : !port_bit_s; // R01

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			address_line20_gate_out <= 1'b0;
			keyboard_system_reset_out <= 1'b0;
			kbd_port_output_bit_out <= 1'b1;
		end else begin
			address_line20_gate_out <= gate_nxt;
			keyboard_system_reset_out <= rst_nxt;
			kbd_port_output_bit_out <= port_nxt;
		end
	end
endmodule // krgc_top

// ==== tb/krgc_checker.sv ====
// assertions for the keyboard reset and gate config block
`timescale 1ns/1ps
module krgc_checker (
	// clock, reset and bus
	input wire mclk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	// pins
	input wire kbd_port_output_bit_in,
	input wire hw_gate_set_in,
	input wire hw_reset_req_in,
	input wire kbd_port_output_bit_out,
	input wire address_line20_gate_out,
	input wire keyboard_system_reset_out
);
	logic [7:0] sel_r;
	logic [1:0] live_r;
	// outputs still carry reset values for three edges after release
	always_ff @(posedge mclk_in or posedge rst_in)
		if (rst_in)
			live_r <= 2'h0;
		else if (live_r != 2'h3)
			live_r <= live_r + 2'h1;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	always_ff @(posedge mclk_in or posedge rst_in)
		if (rst_in)
			sel_r <= 8'h00;
		else if (psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]
			&& paddr_in == 12'h3C0)
			sel_r <= pwdata_in[7:0] & 8'h87;
	sequence rd_at(ok);
		psel_in && !penable_in && !pwrite_in && ok;
	endsequence
	sel_read_a: assert property (rd_at(paddr_in == 12'h3C0)
		|=> prdata_out == {24'h0, sel_r}) else $error("select readback wrong");
	rsvd_zero_a: assert property (rd_at(paddr_in inside {[12'h3C4:12'h3FC]})
		|=> prdata_out == 0) else $error("reserved read not zero");
	p92_off_a: assert property (rd_at(paddr_in == 12'h248 && !sel_r[2])
		|=> prdata_out == 0) else $error("port92 readable while off");
	out_polarity_a: assert property (live_r == 2'h3 && $stable(sel_r) |->
		kbd_port_output_bit_out == ($past(kbd_port_output_bit_in, 3) ~^ sel_r[7]))
		else $error("polarity wrong");
	hw_reset_a: assert property (sel_r[0] && hw_reset_req_in
		|-> ##[1:2] keyboard_system_reset_out) else $error("hw reset missed");
	hw_gate_a: assert property (sel_r[1] && hw_gate_set_in
		|-> ##[1:2] address_line20_gate_out) else $error("hw gate missed");
endmodule // krgc_checker
bind krgc_top krgc_checker chk_i (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.pwdata_in(pwdata_in),
	.pstrb_in(pstrb_in),
	.prdata_out(prdata_out),
	.pready_out(pready_out),
	.kbd_port_output_bit_in(kbd_port_output_bit_in),
	.hw_gate_set_in(hw_gate_set_in),
	.hw_reset_req_in(hw_reset_req_in),
	.kbd_port_output_bit_out(kbd_port_output_bit_out),
	.address_line20_gate_out(address_line20_gate_out),
	.keyboard_system_reset_out(keyboard_system_reset_out)
);

// ==== tb/krgc_host.sv ====
// apb host model issuing register transfers
`timescale 1ns/1ps
module krgc_host (
	// clock and answer
	input wire mclk_in,
	input wire pready_in,
	input wire [31:0] prdata_in,
	// request
	output logic psel_out = 0,
	output logic penable_out = 0,
	output logic pwrite_out = 0,
	output logic [11:0] paddr_out = 0,
	output logic [31:0] pwdata_out = 0
);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge mclk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready_in !== 1'b1);
		q = prdata_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		@(posedge mclk_in);
	endtask
endmodule // krgc_host

// ==== tb/krgc_top_tb.sv ====
// self-checking bench for the keyboard reset and gate config block
`timescale 1ns/1ps
module krgc_top_tb;
	logic mclk_in = 0, rst_in = 1, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, r, x;
	logic [3:0] pstrb_in = 4'h1;
	logic [2:0] hp = 0;
	logic kbd_port_output_bit_in = 0, ctl_address_line20_gate_in = 0;
	logic ctl_keyboard_system_reset_in = 0, kbd_port_output_bit_out;
	logic address_line20_gate_out, keyboard_system_reset_out;
	wire hw_gate_set_in = hp[0], hw_gate_clr_in = hp[1], hw_reset_req_in = hp[2];
	int err_count = 0, num_checks = 0, i, n, sel_m = 0;
	logic slv_err = 0;
	localparam int PULSE_CYC = 500 / 5; // 500 ns reset pulse at a 5 ns clock
	always #2.5 mclk_in = ~mclk_in;
	krgc_host host (.mclk_in(mclk_in), .pready_in(pready_out), .prdata_in(prdata_out),
		.psel_out(psel_in), .penable_out(penable_in), .pwrite_out(pwrite_in),
		.paddr_out(paddr_in), .pwdata_out(pwdata_in));
	krgc_top dut (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.pstrb_in(pstrb_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.kbd_port_output_bit_in(kbd_port_output_bit_in),
		.ctl_address_line20_gate_in(ctl_address_line20_gate_in),
		.ctl_keyboard_system_reset_in(ctl_keyboard_system_reset_in),
		.hw_gate_set_in(hw_gate_set_in),
		.hw_gate_clr_in(hw_gate_clr_in),
		.hw_reset_req_in(hw_reset_req_in),
		.kbd_port_output_bit_out(kbd_port_output_bit_out),
		.address_line20_gate_out(address_line20_gate_out),
		.keyboard_system_reset_out(keyboard_system_reset_out)
	);
	// error flag as it stands in the access cycle
	always @(posedge mclk_in) begin
		if (psel_in && penable_in && pready_out)
			slv_err <= pslverr_out;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, r);
		if (a == 12'h3C0) sel_m = d & 32'h87;
	endtask
	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0, r);
	endtask
	task automatic hit(input logic [2:0] v);
		hp <= v;
		@(posedge mclk_in);
		hp <= 3'h0;
		repeat (3) @(posedge mclk_in);
	endtask
	initial begin
		#20000;
		err_count++;
		final_report();
	end
	initial begin
		void'($urandom(9984));
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		rd(12'h3C0);
		chk(r, 0);
		chk(slv_err, 0);
		for (i = 0; i < 8; i++) begin
			x = $urandom;
			pstrb_in <= x[11:8];
			host.xfer(1'b1, 12'h3C0, x, r);
			if (x[8]) sel_m = x & 32'h87;
			rd(12'h3C0);
			chk(r, sel_m);
		end
		pstrb_in <= 4'hF;
		for (i = 'hF1; i < 'h100; i++) begin
			wr(12'(i * 4), 32'hFF);
			rd(12'(i * 4));
			chk(r, 0);
		end
		rd(12'h004);
		chk(r, 0);
		chk(slv_err, 1);
		rd(12'h3C1);
		chk(r, 0);
		chk(slv_err, 1);
		$display("register test done");
		wr(12'h3C0, 0);
		wr(12'h248, 3);
		rd(12'h248);
		chk(r, 0);
		wr(12'h3C0, 4);
		wr(12'h248, 2);
		rd(12'h248);
		chk(r, 2);
		chk(address_line20_gate_out, 1);
		kbd_port_output_bit_in <= 1'b1;
		for (i = 0; i < 2; i++) begin
			wr(12'h3C0, i << 7);
			repeat (4) @(posedge mclk_in);
			chk(kbd_port_output_bit_out, i);
		end
		wr(12'h3C0, 3);
		hit(3'h4);
		chk(keyboard_system_reset_out, 1);
		hit(3'h1);
		chk(address_line20_gate_out, 1);
		hit(3'h2);
		chk(address_line20_gate_out, 0);
		repeat (110) @(posedge mclk_in);
		wr(12'h3C0, 0);
		hit(3'h4);
		chk(keyboard_system_reset_out, 0);
		$display("pin test done");
		// software control: controller pins steer both outputs
		ctl_address_line20_gate_in <= 1'b1;
		ctl_keyboard_system_reset_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		chk(address_line20_gate_out, 1);
		chk(keyboard_system_reset_out, 1);
		rd(12'h380);
		chk(r, 32'h3);
		ctl_address_line20_gate_in <= 1'b0;
		ctl_keyboard_system_reset_in <= 1'b0;
		wr(12'h3C0, 4);
		repeat (4) @(posedge mclk_in);
		chk(keyboard_system_reset_out, 0);
		wr(12'h248, 1);
		chk(keyboard_system_reset_out, 1);
		// hardware request restarts the pulse; measure its length
		wr(12'h3C0, 1);
		hp <= 3'h4;
		@(posedge mclk_in);
		hp <= 3'h0;
		n = 0;
		@(posedge mclk_in);
		while (keyboard_system_reset_out === 1'b1 && n < 200) begin
			n++;
			@(posedge mclk_in);
		end
		chk(n, PULSE_CYC);
		$display("control test done");
		// reset in mid-run clears the select register
		wr(12'h3C0, 32'h87);
		rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		sel_m = 0;
		@(posedge mclk_in);
		rd(12'h3C0);
		chk(r, sel_m);
		chk(keyboard_system_reset_out, 0);
		chk(kbd_port_output_bit_out, 0);
		$display("reset test done");
		final_report();
	end
endmodule // krgc_top_tb
